// File: core/phynp_map.svh
`ifndef PHYNP_MAP_SVH
`define PHYNP_MAP_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PHYNP_PARTNER_NP_OFS   5'h08
`define PHYNP_EXT_CTRL_OFS     5'h10
// ---------------------------------------------------------------
// partner next-page word fields
// ---------------------------------------------------------------
`define PHYNP_NP_MORE_BIT      15
`define PHYNP_NP_RSVD_BIT      14
`define PHYNP_NP_FMT_BIT       13
`define PHYNP_NP_COMPLY_BIT    12
`define PHYNP_NP_TOGGLE_BIT    11
`define PHYNP_BASE_TOGGLE_BIT  11
`define PHYNP_NP_RESET         16'h0000
// ---------------------------------------------------------------
// extended control fields
// ---------------------------------------------------------------
`define PHYNP_EC_OVR_BIT       15
`define PHYNP_EC_ADDR_HI       10
`define PHYNP_EC_ADDR_LO       6
`define PHYNP_EC_SCR_TEST_BIT  5
`define PHYNP_EC_NRZI_BIT      3
`define PHYNP_EC_BADCODE_BIT   2
`define PHYNP_EC_SCR_DIS_BIT   0
`define PHYNP_EC_SCR_TEST_RST  1'b0
`define PHYNP_EC_NRZI_RST      1'b1
`define PHYNP_EC_BADCODE_RST   1'b0
`define PHYNP_EC_SCR_DIS_RST   1'b0
`endif

// File: core/phynp_pkg.sv
package phynp_pkg;
  // management access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } phynp_mgmt_req_t;

  // decoded extended control settings
  typedef struct packed {
    logic scr_test;
    logic nrzi;
    logic bad_code;
    logic scr_dis;
  } phynp_ctrl_t;

  typedef enum logic [1:0] {
    PHYNP_NP_IDLE   = 2'b00,
    PHYNP_NP_ACTIVE = 2'b01
  } phynp_np_state_t;
endpackage

// File: core/phynp_regs.sv
//Contract
//- next-page flag bit 15: 0 last page, 1 more pages follow.
//- next-page words accepted only when partner also supports next pages.
//- reserved bit 14 of partner word always reads zero.
//- formatted-page flag bit 13: 0 unformatted, 1 message page.
//- can-comply flag bit 12: 0 cannot comply, 1 can comply.
//- toggle alternates per page; first equals inverse of base word bit 11.
//- bits 10:0 carry the 11-bit message or unformatted code.
//- override write enable bit 15 resets 0, self-clears after next write.
//- address bits 10:6 read-only, captured from strap pins at reset.
//- scrambler test mode bit 5, reset 0, 1 enters test mode.
//- setting scrambler test mode forces loss of descrambler lock.
//- bit 2 with tx error maps nibbles to test-pattern codes.
//- bit 0 reset 0, disables scrambler and descrambler when set.
`timescale 1ns/1ps
`default_nettype none
`include "phynp_map.svh"
module phynp_regs (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  // management register port, same clock domain
  input  wire phynp_pkg::phynp_mgmt_req_t mgmt_req_i,
  output var  logic [15:0]               mgmt_rdata_o,
  // auto-negotiation page receive side
  input  wire logic                      partner_np_able_i,
  input  wire logic                      local_np_able_i,
  input  wire logic [15:0]               base_word_i,
  input  wire logic                      base_valid_i,
  input  wire logic                      page_valid_i,
  input  wire logic [15:0]               page_word_i,
  output logic                           page_accept_o,
  output logic                           page_toggle_err_o,
  // strap pins, asynchronous to mclk_i
  input  wire logic                      addr4_strap_pin_i,
  input  wire logic                      addr3_strap_pin_i,
  input  wire logic                      addr2_strap_pin_i,
  input  wire logic                      addr1_strap_pin_i,
  input  wire logic                      addr0_strap_pin_i,
  // control toward datapath
  input  wire logic                      tx_er_i,
  input  wire logic [3:0]                tx_nibble_i,
  output var  logic [4:0]                test_code_o,
  output logic                           use_test_code_o,
  output var  phynp_pkg::phynp_ctrl_t    ctrl_o,
  output var  logic                      force_unlock_o,
  output logic                           override_wr_en_o,
  output logic [4:0]                     phy_addr_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0]               np_word_q;
  logic                      ovr_q;
  logic [4:0]                addr_q;
  logic                      strap_done_q;
  phynp_pkg::phynp_ctrl_t    ctrl_q;
  phynp_pkg::phynp_np_state_t np_st_q;
  logic                      exp_tog_q;
  logic [4:0]                strap_s;

  phynp_sync #(.W(5)) u_strap_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({addr4_strap_pin_i, addr3_strap_pin_i, addr2_strap_pin_i,
              addr1_strap_pin_i, addr0_strap_pin_i}),
    .q_o    (strap_s)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire sel_np   = (mgmt_req_i.addr == `PHYNP_PARTNER_NP_OFS);
  wire sel_ec   = (mgmt_req_i.addr == `PHYNP_EXT_CTRL_OFS);
  wire wr_ec    = mgmt_req_i.wr && sel_ec;
  // partner word is read-only: writes to it are dropped
  wire np_ok    = partner_np_able_i && local_np_able_i;
  wire in_np    = (np_st_q == phynp_pkg::PHYNP_NP_ACTIVE);
  wire tog_ok   = (page_word_i[`PHYNP_NP_TOGGLE_BIT] == exp_tog_q);
  assign page_accept_o     = page_valid_i && np_ok && in_np && tog_ok;
  assign page_toggle_err_o = page_valid_i && np_ok && in_np && !tog_ok;

  wire [15:0] np_load = {page_word_i[`PHYNP_NP_MORE_BIT], 1'b0,
                         page_word_i[13:0]};
  // reserved extended bits read zero
  wire [15:0] ec_rd = {ovr_q, 4'h0, addr_q, ctrl_q.scr_test, 1'b0,
                       ctrl_q.nrzi, ctrl_q.bad_code, 1'b0, ctrl_q.scr_dis};
  wire [15:0] rd_mux = sel_np ? np_word_q : (sel_ec ? ec_rd : 16'h0000);

  assign override_wr_en_o = ovr_q;
  assign phy_addr_o       = addr_q;
  assign use_test_code_o  = ctrl_q.bad_code && tx_er_i;

  // ---------------------------------------------------------------
  // partner next-page capture
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      np_word_q <= `PHYNP_NP_RESET;
      np_st_q   <= phynp_pkg::PHYNP_NP_IDLE;
      exp_tog_q <= 1'b0;
    end else begin
      case (np_st_q)
        phynp_pkg::PHYNP_NP_IDLE: begin
          if (base_valid_i && np_ok) begin
            np_st_q   <= phynp_pkg::PHYNP_NP_ACTIVE;
            exp_tog_q <= ~base_word_i[`PHYNP_BASE_TOGGLE_BIT];
          end
        end
        phynp_pkg::PHYNP_NP_ACTIVE: begin
          if (!np_ok) begin
            np_st_q <= phynp_pkg::PHYNP_NP_IDLE;
          end else if (page_accept_o) begin
            np_word_q <= np_load;
            exp_tog_q <= ~exp_tog_q;
            if (!page_word_i[`PHYNP_NP_MORE_BIT]) begin
              np_st_q <= phynp_pkg::PHYNP_NP_IDLE;
            end
          end
        end
        default: np_st_q <= phynp_pkg::PHYNP_NP_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // extended control
  // ---------------------------------------------------------------
  // reserved write data is not stored; the other party keeps defaults
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ovr_q           <= 1'b0;
      ctrl_q.scr_test <= `PHYNP_EC_SCR_TEST_RST;
      ctrl_q.nrzi     <= `PHYNP_EC_NRZI_RST;
      ctrl_q.bad_code <= `PHYNP_EC_BADCODE_RST;
      ctrl_q.scr_dis  <= `PHYNP_EC_SCR_DIS_RST;
    end else if (mgmt_req_i.wr) begin
      // any write other than the one that sets it consumes the enable
      ovr_q <= wr_ec && mgmt_req_i.wdata[`PHYNP_EC_OVR_BIT];
      if (wr_ec) begin
        ctrl_q.scr_test <= mgmt_req_i.wdata[`PHYNP_EC_SCR_TEST_BIT];
        ctrl_q.nrzi     <= mgmt_req_i.wdata[`PHYNP_EC_NRZI_BIT];
        ctrl_q.bad_code <= mgmt_req_i.wdata[`PHYNP_EC_BADCODE_BIT];
        ctrl_q.scr_dis  <= mgmt_req_i.wdata[`PHYNP_EC_SCR_DIS_BIT];
      end
    end
  end

  // strap capture: the synchroniser output is only valid from the second edge after
  // release, so the sample is taken on the third
  logic [1:0] strap_wait_q;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      addr_q       <= 5'h00;
      strap_done_q <= 1'b0;
      strap_wait_q <= 2'b00;
    end else begin
      strap_wait_q <= {strap_wait_q[0], 1'b1};
      if (strap_wait_q[1] && !strap_done_q) begin
        addr_q       <= strap_s;
        strap_done_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs from flops
  // ---------------------------------------------------------------
  logic [4:0] code_d;
  always_comb begin
    case (tx_nibble_i)
      4'h8:    code_d = 5'h00;
      4'h9:    code_d = 5'h0D;
      4'hA:    code_d = 5'h0C;
      4'hB:    code_d = 5'h11;
      4'hC:    code_d = 5'h10;
      4'hD:    code_d = 5'h19;
      4'hE:    code_d = 5'h18;
      4'hF:    code_d = 5'h1F;
      default: code_d = {1'b0, tx_nibble_i};
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mgmt_rdata_o   <= 16'h0000;
      test_code_o    <= 5'h00;
      ctrl_o         <= '0;
      force_unlock_o <= 1'b0;
    end else begin
      if (mgmt_req_i.rd) begin
        mgmt_rdata_o <= rd_mux;
      end
      test_code_o    <= code_d;
      ctrl_o         <= ctrl_q;
      force_unlock_o <= ctrl_q.scr_test;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_rsvd_zero;
    @(posedge mclk_i) disable iff (rst_i) !np_word_q[`PHYNP_NP_RSVD_BIT];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_np_load;
    @(posedge mclk_i) disable iff (rst_i)
      page_accept_o |=> (np_word_q[13:0] == $past(page_word_i[13:0]))
                        && (np_word_q[15] == $past(page_word_i[15]));
  endproperty
  a_np_load: assert property (p_np_load) else $error("page not loaded");

  property p_np_gate;
    @(posedge mclk_i) disable iff (rst_i)
      !np_ok |=> $stable(np_word_q);
  endproperty
  a_np_gate: assert property (p_np_gate) else $error("page taken without ability");

  property p_tog_alt;
    @(posedge mclk_i) disable iff (rst_i)
      page_accept_o |=> (exp_tog_q != $past(exp_tog_q));
  endproperty
  a_tog_alt: assert property (p_tog_alt) else $error("toggle did not alternate");

  property p_ovr_clr;
    @(posedge mclk_i) disable iff (rst_i)
      ovr_q && mgmt_req_i.wr && !wr_ec |=> !ovr_q;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("override not self-cleared");

  property p_unlock;
    @(posedge mclk_i) disable iff (rst_i)
      wr_ec && mgmt_req_i.wdata[`PHYNP_EC_SCR_TEST_BIT] |=> ##1 force_unlock_o;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock not forced off");

  property p_addr_hold;
    @(posedge mclk_i) disable iff (rst_i)
      strap_done_q |=> $stable(addr_q);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed");

  property p_nrzi_wr;
    @(posedge mclk_i) disable iff (rst_i)
      wr_ec |=> ##1 (ctrl_o.nrzi == $past(mgmt_req_i.wdata[`PHYNP_EC_NRZI_BIT], 2))
                    && (ctrl_o.scr_dis == $past(mgmt_req_i.wdata[`PHYNP_EC_SCR_DIS_BIT], 2));
  endproperty
  a_nrzi_wr: assert property (p_nrzi_wr) else $error("control bit not applied");

  property p_test_use;
    @(posedge mclk_i) disable iff (rst_i)
      use_test_code_o |-> ctrl_q.bad_code && tx_er_i;
  endproperty
  a_test_use: assert property (p_test_use) else $error("test code without enable");

  property p_low_code;
    @(posedge mclk_i) disable iff (rst_i)
      !tx_nibble_i[3] |=> (test_code_o == {1'b0, $past(tx_nibble_i)});
  endproperty
  a_low_code: assert property (p_low_code) else $error("low nibble code wrong");

  property p_k_code;
    @(posedge mclk_i) disable iff (rst_i)
      (tx_nibble_i == 4'hB) |=> (test_code_o == 5'h11);
  endproperty
  a_k_code: assert property (p_k_code) else $error("nibble B code wrong");

  property p_rd_np;
    @(posedge mclk_i) disable iff (rst_i)
      mgmt_req_i.rd && sel_np |=> (mgmt_rdata_o == $past(np_word_q));
  endproperty
  a_rd_np: assert property (p_rd_np) else $error("partner word read wrong");

  property p_rd_addr;
    @(posedge mclk_i) disable iff (rst_i)
      mgmt_req_i.rd && sel_ec && strap_done_q
        |=> (mgmt_rdata_o[`PHYNP_EC_ADDR_HI:`PHYNP_EC_ADDR_LO] == phy_addr_o);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("address field read wrong");

  property p_ovr_set;
    @(posedge mclk_i) disable iff (rst_i)
      wr_ec && mgmt_req_i.wdata[`PHYNP_EC_OVR_BIT] |=> ovr_q;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("override not set");

  property p_unlock_off;
    @(posedge mclk_i) disable iff (rst_i)
      !ctrl_q.scr_test |=> !force_unlock_o;
  endproperty
  a_unlock_off: assert property (p_unlock_off) else $error("lock forced off in normal mode");

  property p_terr_keep;
    @(posedge mclk_i) disable iff (rst_i)
      page_toggle_err_o |=> $stable(np_word_q);
  endproperty
  a_terr_keep: assert property (p_terr_keep) else $error("mistoggled page stored");

  property p_exch_end;
    @(posedge mclk_i) disable iff (rst_i)
      page_accept_o && !page_word_i[`PHYNP_NP_MORE_BIT] |=> !in_np;
  endproperty
  a_exch_end: assert property (p_exch_end) else $error("exchange kept after last page");

  property p_more_stay;
    @(posedge mclk_i) disable iff (rst_i)
      page_accept_o && page_word_i[`PHYNP_NP_MORE_BIT] |=> in_np;
  endproperty
  a_more_stay: assert property (p_more_stay) else $error("exchange left with pages pending");

  property p_addr_cap;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(strap_done_q) |-> (addr_q == $past(strap_s));
  endproperty
  a_addr_cap: assert property (p_addr_cap) else $error("strap address not captured");
endmodule
`default_nettype wire

// File: core/phynp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pin levels
module phynp_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: verif/phynp_sta_model.sv
`timescale 1ns/1ps
`default_nettype none
module phynp_sta_model (
  input  wire logic                       mclk_i,
  input  wire logic [15:0]                mgmt_rdata_i,
  output var  phynp_pkg::phynp_mgmt_req_t mgmt_req_o
);
  // reserved bits stay at their zero default on every write
  localparam logic [15:0] EXT_RSVD = 16'h7812;
  localparam logic [15:0] NP_RSVD  = 16'h4000;
  initial mgmt_req_o = '0;
  // released lines show the inverse, never the last value
  task automatic mgmt_write(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    mgmt_req_o.addr  = a;
    mgmt_req_o.wdata = d & ~((a == 5'h10) ? EXT_RSVD : NP_RSVD);
    mgmt_req_o.wr    = 1'b1;
    @(negedge mclk_i);
    mgmt_req_o.wr    = 1'b0;
    mgmt_req_o.addr  = ~mgmt_req_o.addr;
    mgmt_req_o.wdata = ~mgmt_req_o.wdata;
  endtask
  task automatic mgmt_read(input logic [4:0] a, output logic [15:0] d);
    @(negedge mclk_i);
    mgmt_req_o.addr = a;
    mgmt_req_o.rd   = 1'b1;
    @(negedge mclk_i);
    d               = mgmt_rdata_i;
    mgmt_req_o.rd   = 1'b0;
    mgmt_req_o.addr = ~mgmt_req_o.addr;
  endtask
endmodule
`default_nettype wire

// File: verif/tb_phy_np_partner_ext_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_phy_np_partner_ext_ctrl_regs;
  localparam logic [4:0]  STRAP   = 5'h16;
  localparam logic [15:0] EXT_RST = {5'h00, STRAP, 6'h08};
  localparam logic [79:0] TCODE   = {5'h1F, 5'h18, 5'h19, 5'h10, 5'h11, 5'h0C, 5'h0D, 5'h00,
                                     5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  logic mclk_i = 1'b0, rst_i = 1'b1, p_able = 1'b0, l_able = 1'b0, b_vld = 1'b0, pg_vld = 1'b0;
  logic tx_er = 1'b0, acc, terr, use_tc, unlock, ovr;
  logic [15:0] b_word = '0, pg_word = '0, rdata, d;
  logic [3:0]  nib = '0;
  logic [4:0]  tcode, paddr;
  logic [4:0]  strap = STRAP;
  phynp_pkg::phynp_mgmt_req_t req;
  phynp_pkg::phynp_ctrl_t     ctrl;
  int fails = 0, num_checks = 0;
  always #10 mclk_i = ~mclk_i;
  phynp_sta_model phynp_sta_model_inst (.mclk_i(mclk_i), .mgmt_rdata_i(rdata), .mgmt_req_o(req));
  phynp_regs phynp_regs_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .mgmt_req_i(req), .mgmt_rdata_o(rdata),
    .partner_np_able_i(p_able), .local_np_able_i(l_able), .base_word_i(b_word),
    .base_valid_i(b_vld), .page_valid_i(pg_vld), .page_word_i(pg_word),
    .page_accept_o(acc), .page_toggle_err_o(terr),
    .addr4_strap_pin_i(strap[4]), .addr3_strap_pin_i(strap[3]), .addr2_strap_pin_i(strap[2]),
    .addr1_strap_pin_i(strap[1]), .addr0_strap_pin_i(strap[0]),
    .tx_er_i(tx_er), .tx_nibble_i(nib), .test_code_o(tcode), .use_test_code_o(use_tc),
    .ctrl_o(ctrl), .force_unlock_o(unlock), .override_wr_en_o(ovr), .phy_addr_o(paddr));
  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic finish_test;
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string msg);
    phynp_sta_model_inst.mgmt_read(a, d);
    check(d, exp, msg);
  endtask
  task automatic base(input logic [15:0] w);
    @(negedge mclk_i);
    b_word = w;
    b_vld  = 1'b1;
    @(negedge mclk_i);
    b_vld  = 1'b0;
    b_word = ~w;
  endtask
  task automatic page(input logic [15:0] w, input logic a, input logic e);
    @(negedge mclk_i);
    pg_word = w;
    pg_vld  = 1'b1;
    #1;
    check({14'h0, acc, terr}, {14'h0, a, e}, "page response");
    @(negedge mclk_i);
    pg_vld  = 1'b0;
    pg_word = ~w;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd_chk(5'h08, 16'h0000, "np word reset");
    rd_chk(5'h10, EXT_RST, "ext reset");
    check({12'h0, ctrl}, 16'h0004, "ctrl reset");
    check({11'h0, paddr}, {11'h0, STRAP}, "strap addr");
  endtask
  task automatic t_ctrl;
    // address bits written as all ones must not stick
    phynp_sta_model_inst.mgmt_write(5'h10, 16'h07E5);
    rd_chk(5'h10, {5'h00, STRAP, 6'h25}, "ext write");
    check({12'h0, ctrl}, 16'h000B, "ctrl set");
    check({15'h0, unlock}, 16'h0001, "unlock");
    for (int i = 0; i < 16; i++) begin
      @(negedge mclk_i);
      if (i > 0) check({11'h0, tcode}, {11'h0, TCODE[(i-1)*5 +: 5]}, "test code");
      nib   = 4'(i);
      tx_er = 1'b1;
      #1;
      check({15'h0, use_tc}, 16'h0001, "use test code");
    end
    @(negedge mclk_i);
    check({11'h0, tcode}, {11'h0, TCODE[75 +: 5]}, "test code last");
    tx_er = 1'b0;
    #1;
    check({15'h0, use_tc}, 16'h0000, "no tx error");
    phynp_sta_model_inst.mgmt_write(5'h10, 16'h0008);
    rd_chk(5'h10, EXT_RST, "ext restore");
    check({8'h0, ctrl, 3'h0, unlock}, 16'h0040, "ctrl restore");
  endtask
  task automatic t_override;
    phynp_sta_model_inst.mgmt_write(5'h10, 16'h8008);
    check({15'h0, ovr}, 16'h0001, "override set");
    rd_chk(5'h10, EXT_RST | 16'h8000, "override read");
    phynp_sta_model_inst.mgmt_write(5'h08, 16'hFFFF);
    check({15'h0, ovr}, 16'h0000, "override cleared");
    rd_chk(5'h08, 16'h0000, "np word read only");
  endtask
  task automatic t_pages;
    p_able = 1'b1;
    l_able = 1'b1;
    base(16'h0800);
    page(16'hF5A5, 1'b1, 1'b0);
    rd_chk(5'h08, 16'hB5A5, "page one");
    page(16'h75A5, 1'b0, 1'b1);
    rd_chk(5'h08, 16'hB5A5, "stale toggle dropped");
    page(16'h0A5A, 1'b1, 1'b0);
    rd_chk(5'h08, 16'h0A5A, "last page");
    page(16'h8000, 1'b0, 1'b0);
    p_able = 1'b0;
    base(16'h0000);
    page(16'h8800, 1'b0, 1'b0);
    p_able = 1'b1;
    base(16'h0000);
    page(16'h3800, 1'b1, 1'b0);
    rd_chk(5'h08, 16'h3800, "inverse base toggle");
  endtask
  task automatic t_rereset;
    // straps move while reset is held; the new level must be taken on release
    phynp_sta_model_inst.mgmt_write(5'h10, 16'h0025);
    @(negedge mclk_i);
    rst_i = 1'b1;
    strap = 5'h09;
    repeat (4) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    check({11'h0, paddr}, 16'h0009, "strap recapture");
    check({12'h0, ctrl}, 16'h0004, "ctrl reset again");
    rd_chk(5'h10, 16'h0248, "ext reset again");
    rd_chk(5'h08, 16'h0000, "np word reset again");
  endtask
  initial begin
    repeat (16) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    t_reset();
    t_ctrl();
    t_override();
    t_pages();
    t_rereset();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
